// ### rtl/shcfg_pkg.sv
// Package: register map, field layout, timing and carrier types of the hub channel config
package shcfg_pkg;
    // ============================================================
    // Register indices (byte address is four times the index)
    localparam logic [7:0] IDX_S1_ADDR = 8'h15;
    localparam logic [7:0] IDX_S1_TREG = 8'h16;
    localparam logic [7:0] IDX_S1_CFG = 8'h17;
    localparam logic [7:0] IDX_S2_ADDR = 8'h18;
    localparam logic [7:0] IDX_S2_TREG = 8'h19;
    localparam logic [7:0] IDX_S2_CFG = 8'h1a;
    localparam logic [7:0] IDX_S3_ADDR = 8'h1b;
    localparam logic [7:0] IDX_S3_TREG = 8'h1c;
    localparam logic [7:0] IDX_HUB_CTRL = 8'h30;
    localparam logic [7:0] IDX_HUB_STAT = 8'h31;
    localparam int ADDR_LSB = 2;
    localparam int IDX_W = 8;

    // ============================================================
    // Field layout
    localparam int ADDR_RW_BIT = 0;
    localparam int ADDR_MSB = 7;
    localparam int ADDR_LSB7 = 1;
    localparam int CFG_RATE_MSB = 7;
    localparam int CFG_RATE_LSB = 6;
    localparam int CFG_BATCH_BIT = 3;
    localparam int CFG_CNT_MSB = 2;
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_NSENS_MSB = 2;
    localparam int CTRL_NSENS_LSB = 1;
    localparam int CTRL_TRIG_BIT = 3;
    localparam int CTRL_WONCE_BIT = 4;
    localparam int CTRL_S3CNT_MSB = 10;
    localparam int CTRL_S3CNT_LSB = 8;
    localparam int CTRL_S3BATCH_BIT = 11;
    localparam int CTRL_WDATA_MSB = 23;
    localparam int CTRL_WDATA_LSB = 16;
    localparam int STAT_ENDOP_BIT = 0;
    localparam int STAT_BUSY_BIT = 1;
    localparam int STAT_NACK_LSB = 2;
    localparam int STAT_WODONE_BIT = 5;
    localparam int NUM_CH = 3;

    // ============================================================
    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    // ============================================================
    // Hub rates in millihertz and the cycle counts they give at pclk
    localparam longint CLK_HZ = 100_000_000;
    localparam longint RATE_104_MHZ = 104_000;
    localparam longint RATE_52_MHZ = 52_000;
    localparam longint RATE_26_MHZ = 26_000;
    localparam longint RATE_12P5_MHZ = 12_500;
    localparam int PER_104_CYC = int'(CLK_HZ * 1000 / RATE_104_MHZ);
    localparam int PER_52_CYC = int'(CLK_HZ * 1000 / RATE_52_MHZ);
    localparam int PER_26_CYC = int'(CLK_HZ * 1000 / RATE_26_MHZ);
    localparam int PER_12P5_CYC = int'(CLK_HZ * 1000 / RATE_12P5_MHZ);
    localparam int RATE_CNT_W = 24;

    // ============================================================
    // Carrier types
    typedef struct packed {
        logic [1:0] chan;
        logic [6:0] bus_addr;
        logic rd;
        logic [7:0] target_reg;
        logic [7:0] wdata;
        logic [2:0] read_count;
        logic fifo_batch_en;
    } shcfg_txn_s;

    typedef struct packed {
        logic done;
        logic noack;
    } shcfg_resp_s;
endpackage

// ### rtl/shcfg_sync.sv
// Two-flop synchroniser with rising-edge pulse for an asynchronous pin
`timescale 1ns/10ps
`default_nettype none
module shcfg_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic async_in,
    output logic level_out,
    output logic rise_pulse
);
    logic meta_r;
    logic sync_r;
    logic prev_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            prev_r <= 1'b0;
        end else begin
            meta_r <= async_in;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    // Edge taken from the second flop only
    assign level_out = sync_r;
    assign rise_pulse = sync_r & ~prev_r;
endmodule
`default_nettype wire

// ### rtl/shcfg_rate.sv
// Hub cycle rate divider: one-cycle tick at the effective hub rate
`timescale 1ns/10ps
`default_nettype none
module shcfg_rate #(
    parameter int PER_104 = shcfg_pkg::PER_104_CYC,
    parameter int PER_52 = shcfg_pkg::PER_52_CYC,
    parameter int PER_26 = shcfg_pkg::PER_26_CYC,
    parameter int PER_12P5 = shcfg_pkg::PER_12P5_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic [1:0] rate_code,
    output logic tick
);
    localparam int CW = shcfg_pkg::RATE_CNT_W;
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] period;

    always_comb begin
        case (rate_code)
            2'h0: period = CW'(PER_104);
            2'h1: period = CW'(PER_52);
            2'h2: period = CW'(PER_26);
            default: period = CW'(PER_12P5);
        endcase
    end

    assign tick = run && (cnt_r >= period - CW'(1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= '0;
        end else if (!run || tick) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + CW'(1);
        end
    end
endmodule
`default_nettype wire

// ### rtl/shcfg_top.sv
// Sensor hub channel configuration registers and channel sequencer, APB slave
`timescale 1ns/10ps
`default_nettype none
module shcfg_top #(
    parameter int PER_104 = shcfg_pkg::PER_104_CYC,
    parameter int PER_52 = shcfg_pkg::PER_52_CYC,
    parameter int PER_26 = shcfg_pkg::PER_26_CYC,
    parameter int PER_12P5 = shcfg_pkg::PER_12P5_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] motion_rate_code,
    input wire logic motion_drdy,
    input wire logic ext_trigger_pin,
    output logic txn_valid,
    input wire logic txn_ready,
    output shcfg_pkg::shcfg_txn_s txn_req,
    input wire shcfg_pkg::shcfg_resp_s txn_resp,
    output logic hub_busy,
    output logic hub_cycle_done
);
    localparam int NCH = shcfg_pkg::NUM_CH;

    // ============================================================
    // Register storage
    logic [7:0] s1_addr_r;
    logic [7:0] s1_treg_r;
    logic [7:0] s1_cfg_r;
    logic [7:0] s2_addr_r;
    logic [7:0] s2_treg_r;
    logic [7:0] s2_cfg_r;
    logic [7:0] s3_addr_r;
    logic [7:0] s3_treg_r;
    logic [31:0] ctrl_r;
    logic endop_r;
    logic [NCH-1:0] noack_r;
    logic wonce_done_r;

    // ============================================================
    // APB decode
    logic [shcfg_pkg::IDX_W-1:0] idx;
    logic setup;
    logic wr_acc;
    logic mapped;
    logic [31:0] rd_word;
    logic [31:0] stat_word;

    assign idx = paddr[shcfg_pkg::ADDR_LSB +: shcfg_pkg::IDX_W];
    assign setup = psel & ~penable;
    assign wr_acc = psel & penable & pwrite & mapped & pstrb[0];
    assign pready = 1'b1;

    always_comb begin
        mapped = 1'b1;
        rd_word = shcfg_pkg::RST_WORD;
        case (idx)
            shcfg_pkg::IDX_S1_ADDR: rd_word[7:0] = s1_addr_r;
            shcfg_pkg::IDX_S1_TREG: rd_word[7:0] = s1_treg_r;
            shcfg_pkg::IDX_S1_CFG: rd_word[7:0] = s1_cfg_r;
            shcfg_pkg::IDX_S2_ADDR: rd_word[7:0] = s2_addr_r;
            shcfg_pkg::IDX_S2_TREG: rd_word[7:0] = s2_treg_r;
            shcfg_pkg::IDX_S2_CFG: rd_word[7:0] = s2_cfg_r;
            shcfg_pkg::IDX_S3_ADDR: rd_word[7:0] = s3_addr_r;
            shcfg_pkg::IDX_S3_TREG: rd_word[7:0] = s3_treg_r;
            shcfg_pkg::IDX_HUB_CTRL: rd_word = ctrl_r;
            shcfg_pkg::IDX_HUB_STAT: rd_word = stat_word;
            default: mapped = 1'b0;
        endcase
    end

    // Read data sampled in setup so the access phase needs no wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= shcfg_pkg::RST_WORD;
        end else if (setup && !pwrite) begin
            prdata <= rd_word;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else if (setup) begin
            pslverr <= ~mapped;
        end
    end

    // ============================================================
    // Channel configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_addr_r <= shcfg_pkg::RST_BYTE;
            s1_treg_r <= shcfg_pkg::RST_BYTE;
            s1_cfg_r <= shcfg_pkg::RST_BYTE;
            s2_addr_r <= shcfg_pkg::RST_BYTE;
            s2_treg_r <= shcfg_pkg::RST_BYTE;
            s2_cfg_r <= shcfg_pkg::RST_BYTE;
            s3_addr_r <= shcfg_pkg::RST_BYTE;
            s3_treg_r <= shcfg_pkg::RST_BYTE;
        end else if (wr_acc) begin
            case (idx)
                shcfg_pkg::IDX_S1_ADDR: s1_addr_r <= pwdata[7:0];
                shcfg_pkg::IDX_S1_TREG: s1_treg_r <= pwdata[7:0];
                // Reserved bits held at zero whatever software writes
                shcfg_pkg::IDX_S1_CFG: s1_cfg_r <= pwdata[7:0] & 8'hcf;
                shcfg_pkg::IDX_S2_ADDR: s2_addr_r <= pwdata[7:0];
                shcfg_pkg::IDX_S2_TREG: s2_treg_r <= pwdata[7:0];
                shcfg_pkg::IDX_S2_CFG: s2_cfg_r <= pwdata[7:0] & 8'h0f;
                shcfg_pkg::IDX_S3_ADDR: s3_addr_r <= pwdata[7:0];
                shcfg_pkg::IDX_S3_TREG: s3_treg_r <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    // Hub control word; byte lanes honoured as it is wider than a byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= shcfg_pkg::RST_WORD;
        end else if (psel && penable && pwrite && idx == shcfg_pkg::IDX_HUB_CTRL) begin
            for (int b = 0; b < 4; b++) begin
                if (pstrb[b]) begin
                    ctrl_r[8*b +: 8] <= pwdata[8*b +: 8];
                end
            end
        end
    end

    logic hub_en;
    logic [1:0] hub_sensor_count;
    logic trig_sel;
    logic first_cycle_write_only;
    assign hub_en = ctrl_r[shcfg_pkg::CTRL_EN_BIT];
    assign hub_sensor_count = ctrl_r[shcfg_pkg::CTRL_NSENS_MSB:shcfg_pkg::CTRL_NSENS_LSB];
    assign trig_sel = ctrl_r[shcfg_pkg::CTRL_TRIG_BIT];
    assign first_cycle_write_only = ctrl_r[shcfg_pkg::CTRL_WONCE_BIT];

    // ============================================================
    // Per-channel view of the configuration
    logic [6:0] ch_addr [NCH];
    logic [7:0] ch_treg [NCH];
    logic [NCH-1:0] ch_rd;
    logic [NCH-1:0] ch_batch;
    logic [2:0] ch_cnt [NCH];
    logic [7:0] addr_reg [NCH];
    logic [NCH-1:0] ch_on;

    assign addr_reg[0] = s1_addr_r;
    assign addr_reg[1] = s2_addr_r;
    assign addr_reg[2] = s3_addr_r;
    assign ch_treg[0] = s1_treg_r;
    assign ch_treg[1] = s2_treg_r;
    assign ch_treg[2] = s3_treg_r;
    assign ch_batch[0] = s1_cfg_r[shcfg_pkg::CFG_BATCH_BIT];
    assign ch_batch[1] = s2_cfg_r[shcfg_pkg::CFG_BATCH_BIT];
    assign ch_batch[2] = ctrl_r[shcfg_pkg::CTRL_S3BATCH_BIT];
    assign ch_cnt[0] = s1_cfg_r[shcfg_pkg::CFG_CNT_MSB:0];
    assign ch_cnt[1] = s2_cfg_r[shcfg_pkg::CFG_CNT_MSB:0];
    assign ch_cnt[2] = ctrl_r[shcfg_pkg::CTRL_S3CNT_MSB:shcfg_pkg::CTRL_S3CNT_LSB];

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            assign ch_addr[g] = addr_reg[g][shcfg_pkg::ADDR_MSB:shcfg_pkg::ADDR_LSB7];
            assign ch_rd[g] = addr_reg[g][shcfg_pkg::ADDR_RW_BIT];
            // Channel serviced when within the sensor count; 2 and 3 need read enable
            if (g == 0) begin : g_first
                assign ch_on[g] = 1'b1;
            end else begin : g_rest
                assign ch_on[g] = (hub_sensor_count >= 2'(g)) && ch_rd[g];
            end
        end
    endgenerate

    // ============================================================
    // Hub trigger: rate tick or synchronised external pin
    logic [1:0] motion_code_eff;
    logic [1:0] rate_eff;
    logic rate_tick;
    logic pin_rise;
    logic hub_trigger;
    logic [1:0] hub_rate_sel;

    assign hub_rate_sel = s1_cfg_r[shcfg_pkg::CFG_RATE_MSB:shcfg_pkg::CFG_RATE_LSB];
    assign motion_code_eff = motion_rate_code;
    // Larger code is slower; pick the slower of selected hub rate and motion rate
    assign rate_eff = (motion_code_eff > hub_rate_sel) ? motion_code_eff : hub_rate_sel;

    shcfg_rate #(
        .PER_104(PER_104),
        .PER_52(PER_52),
        .PER_26(PER_26),
        .PER_12P5(PER_12P5)
    ) u_rate (
        .pclk(pclk),
        .presetn(presetn),
        .run(hub_en),
        .rate_code(rate_eff),
        .tick(rate_tick)
    );

    shcfg_sync u_pin (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(ext_trigger_pin),
        .level_out(),
        .rise_pulse(pin_rise)
    );

    // Rate-paced data-ready is held pending until the next motion data-ready
    logic tick_pend_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_pend_r <= 1'b0;
        end else if (!hub_en || trig_sel) begin
            tick_pend_r <= 1'b0;
        end else if (rate_tick) begin
            tick_pend_r <= 1'b1;
        end else if (motion_drdy) begin
            tick_pend_r <= 1'b0;
        end
    end

    assign hub_trigger = hub_en && (trig_sel ? pin_rise : (tick_pend_r && motion_drdy));

    // ============================================================
    // Channel sequencer
    typedef enum logic [1:0] {ST_IDLE, ST_SCAN, ST_ISSUE, ST_WAIT} shcfg_state_e;
    shcfg_state_e state_r;
    logic [1:0] ch_r;
    logic ch0_skip;
    logic ch_go;

    // Sensor 1 write suppressed after the first acknowledged write when first_cycle_write_only
    assign ch0_skip = !ch_rd[0] && first_cycle_write_only && wonce_done_r;
    assign ch_go = ch_on[ch_r] && !(ch_r == 2'd0 && ch0_skip);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_IDLE;
            ch_r <= 2'd0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (hub_trigger) begin
                        state_r <= ST_SCAN;
                        ch_r <= 2'd0;
                    end
                end
                ST_SCAN: begin
                    if (32'(ch_r) >= NCH) begin
                        state_r <= ST_IDLE;
                    end else if (ch_go) begin
                        state_r <= ST_ISSUE;
                    end else begin
                        ch_r <= ch_r + 2'd1;
                    end
                end
                ST_ISSUE: begin
                    if (txn_ready) begin
                        state_r <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (txn_resp.done) begin
                        state_r <= ST_SCAN;
                        ch_r <= ch_r + 2'd1;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // Request fields from flops, loaded as the channel is chosen
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txn_req <= '0;
        end else if (state_r == ST_SCAN && 32'(ch_r) < NCH && ch_go) begin
            txn_req.chan <= ch_r;
            txn_req.bus_addr <= ch_addr[ch_r];
            // Channels 2 and 3 only ever read
            txn_req.rd <= (ch_r == 2'd0) ? ch_rd[0] : 1'b1;
            txn_req.target_reg <= ch_treg[ch_r];
            txn_req.wdata <= ctrl_r[shcfg_pkg::CTRL_WDATA_MSB:shcfg_pkg::CTRL_WDATA_LSB];
            txn_req.read_count <= ch_cnt[ch_r];
            txn_req.fifo_batch_en <= ch_batch[ch_r];
        end
    end

    assign txn_valid = (state_r == ST_ISSUE);
    assign hub_busy = (state_r != ST_IDLE);
    assign hub_cycle_done = (state_r == ST_SCAN) && (32'(ch_r) >= NCH);

    // ============================================================
    // Status flags: hardware set wins over a write-one clear
    logic stat_wr;
    logic [NCH-1:0] noack_set;
    logic wonce_set;
    assign stat_wr = psel && penable && pwrite && pstrb[0] && idx == shcfg_pkg::IDX_HUB_STAT;
    assign wonce_set = (state_r == ST_WAIT) && txn_resp.done && (txn_req.chan == 2'd0)
        && !txn_req.rd && !txn_resp.noack;

    generate
        for (g = 0; g < NCH; g++) begin : g_nack
            assign noack_set[g] = (state_r == ST_WAIT) && txn_resp.done && txn_resp.noack
                && (txn_req.chan == 2'(g));
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    noack_r[g] <= 1'b0;
                end else if (noack_set[g]) begin
                    noack_r[g] <= 1'b1;
                end else if (stat_wr && pwdata[shcfg_pkg::STAT_NACK_LSB + g]) begin
                    noack_r[g] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wonce_done_r <= 1'b0;
        end else if (wonce_set && first_cycle_write_only) begin
            wonce_done_r <= 1'b1;
        end else if (stat_wr && pwdata[shcfg_pkg::STAT_WODONE_BIT]) begin
            wonce_done_r <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            endop_r <= 1'b0;
        end else if (hub_cycle_done) begin
            endop_r <= 1'b1;
        end else if (hub_trigger && state_r == ST_IDLE) begin
            endop_r <= 1'b0;
        end
    end

    always_comb begin
        stat_word = shcfg_pkg::RST_WORD;
        stat_word[shcfg_pkg::STAT_ENDOP_BIT] = endop_r;
        stat_word[shcfg_pkg::STAT_BUSY_BIT] = hub_busy;
        stat_word[shcfg_pkg::STAT_NACK_LSB +: NCH] = noack_r;
        stat_word[shcfg_pkg::STAT_WODONE_BIT] = wonce_done_r;
    end
endmodule
`default_nettype wire

// ### tb/shcfg_assertions.sv
// Checker: port-level properties of the hub channel config block
`timescale 1ns/10ps
`default_nettype none
module shcfg_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic txn_valid,
    input wire logic txn_ready,
    input wire shcfg_pkg::shcfg_txn_s txn_req,
    input wire logic hub_busy,
    input wire logic hub_cycle_done
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic rd_acc = psel && penable && !pwrite;
    // ==========
    // Transaction port
    hold_req_a: assert property (txn_valid && !txn_ready |=> txn_valid && $stable(txn_req))
        else $error("request changed before taken");
    one_out_a: assert property (txn_valid && txn_ready |=> !txn_valid)
        else $error("second request while one outstanding");
    rd_only_a: assert property (txn_valid && txn_req.chan != 2'h0 |-> txn_req.rd)
        else $error("write issued on a read-only channel");
    no_fourth_a: assert property (txn_valid |-> txn_req.chan != 2'h3)
        else $error("fourth channel serviced");
    busy_req_a: assert property (txn_valid |-> hub_busy)
        else $error("request outside hub cycle");
    end_cycle_a: assert property (hub_cycle_done |-> !txn_valid && $past(hub_busy))
        else $error("cycle end without running cycle");
    end_pulse_a: assert property (hub_cycle_done |=> !hub_cycle_done)
        else $error("cycle end longer than one cycle");
    // ==========
    // Register reads
    resv_one_a: assert property (rd_acc && paddr[9:2] == 8'h17 |-> prdata[5:4] == 2'h0)
        else $error("reserved bits of channel 1 config set");
    resv_two_a: assert property (rd_acc && paddr[9:2] == 8'h1a |-> prdata[7:4] == 4'h0)
        else $error("reserved bits of channel 2 config set");
    cover property (hub_cycle_done);
    cover property (rd_acc && pslverr);
    cover property (txn_valid && txn_ready && !txn_req.rd);
endmodule
bind shcfg_top shcfg_checker chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata,
    .pslverr, .txn_valid, .txn_ready, .txn_req, .hub_busy, .hub_cycle_done);
`default_nettype wire

// ### tb/shcfg_sensor_model.sv
// Partner model: external sensors answering hub transactions
`timescale 1ns/10ps
`default_nettype none
module shcfg_sensor_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic txn_valid,
    output logic txn_ready,
    input wire shcfg_pkg::shcfg_txn_s txn_req,
    output shcfg_pkg::shcfg_resp_s txn_resp,
    input wire logic [6:0] nack_addr
);
    shcfg_pkg::shcfg_txn_s log_q[$];
    logic [6:0] cur_addr;
    int cnt;
    // ==========
    // One request at a time, answer three cycles after taking it
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txn_ready <= 1'b0;
            txn_resp <= '0;
            cnt <= 0;
            cur_addr <= 7'h0;
        end else begin
            txn_ready <= txn_valid && !txn_ready && cnt == 0;
            txn_resp.done <= (cnt == 1);
            txn_resp.noack <= (cnt == 1) && (cur_addr == nack_addr);
            if (txn_valid && txn_ready) begin
                log_q.push_back(txn_req);
                cur_addr <= txn_req.bus_addr;
                cnt <= 3;
            end else if (cnt > 0) begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule
`default_nettype wire

// ### tb/tb.sv
// Testbench: register map, hub cycle order and hub rate of the channel config block
`timescale 1ns/10ps
`default_nettype none
module tb;
    localparam int P1 = 40;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd_q;
    logic pready, pslverr, err_q, txn_valid, txn_ready, hub_busy, hub_cycle_done;
    logic [1:0] motion_rate_code = 2'h0;
    logic motion_drdy = 1'b0;
    logic ext_trigger_pin = 1'b0;
    logic [6:0] nack_addr = 7'h0;
    shcfg_pkg::shcfg_txn_s txn_req;
    shcfg_pkg::shcfg_resp_s txn_resp;
    int bad_count = 0;
    int n_checks = 0;
    always #5 pclk = ~pclk;
    shcfg_top #(.PER_104(P1), .PER_52(2 * P1), .PER_26(3 * P1), .PER_12P5(4 * P1)) dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hf), .prdata,
        .pready, .pslverr, .motion_rate_code, .motion_drdy, .ext_trigger_pin, .txn_valid,
        .txn_ready, .txn_req, .txn_resp, .hub_busy, .hub_cycle_done);
    shcfg_sensor_model snsr (.pclk, .presetn, .txn_valid, .txn_ready, .txn_req, .txn_resp,
        .nack_addr);
    // ==========
    // Shared tasks
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {22'h0, idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a stalled access
        do @(posedge pclk); while (pready !== 1'b1);
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_done(output int cyc);
        cyc = 0;
        do begin
            @(posedge pclk);
            cyc++;
        end while (hub_cycle_done !== 1'b1 && cyc < 5000);
        if (hub_cycle_done !== 1'b1) begin
            bad_count++;
        end
    endtask
    // ==========
    // Scenarios
    task automatic t_regs();
        logic [7:0] idx;
        logic [31:0] wd;
        for (int i = 0; i < 8; i++) begin
            idx = 8'h15 + 8'(i);
            apb(1'b0, idx, 32'h0);
            cmp(rd_q, 32'h0);
            // Software keeps reserved config bits at zero
            wd = idx == 8'h17 ? 32'hcf : idx == 8'h1a ? 32'h0f : 32'hff;
            apb(1'b1, idx, wd);
            apb(1'b0, idx, 32'h0);
            cmp(rd_q, wd);
        end
        apb(1'b0, 8'h20, 32'h0);
        cmp({rd_q[30:0], err_q}, 32'h1);
    endtask
    task automatic t_cycle();
        logic [7:0] d[9] = '{8'h55, 8'h3c, 8'h0b, 8'h67, 8'h11, 8'h05, 8'h49, 8'h7e, 8'h0d};
        int c;
        for (int i = 0; i < 9; i++) begin
            apb(1'b1, i < 8 ? 8'h15 + 8'(i) : 8'h30, {24'h0, d[i]});
        end
        nack_addr <= 7'h33;
        ext_trigger_pin <= 1'b1;
        wait_done(c);
        ext_trigger_pin <= 1'b0;
        cmp(32'(snsr.log_q.size()), 32'h3);
        cmp(32'(snsr.log_q[0]), {4'h0, 7'h2a, 1'b1, 16'h3c00, 4'h7});
        cmp(32'(snsr.log_q[1]), {4'h1, 7'h33, 1'b1, 16'h1100, 4'ha});
        cmp(32'(snsr.log_q[2]), {4'h2, 7'h24, 1'b1, 16'h7e00, 4'h0});
        apb(1'b0, 8'h31, 32'h0);
        cmp(rd_q & 32'h1c, 32'h08);
    endtask
    task automatic t_rate();
        logic [1:0] hub_c[4] = '{2'h0, 2'h1, 2'h1, 2'h0};
        logic [1:0] mot_c[4] = '{2'h0, 2'h0, 2'h2, 2'h3};
        int per_c[4] = '{P1, 2 * P1, 3 * P1, 4 * P1};
        int c;
        int s;
        apb(1'b1, 8'h15, 32'h54);
        apb(1'b1, 8'h30, 32'h00a5_0001);
        motion_drdy <= 1'b1;
        // Every effective rate code once, motion rate slower in the last two
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, 8'h17, {24'h0, hub_c[m], 6'h00});
            motion_rate_code <= mot_c[m];
            wait_done(c);
            wait_done(c);
            wait_done(c);
            cmp(32'(c), 32'(per_c[m]));
        end
        cmp(32'(snsr.log_q[$]), {4'h0, 7'h2a, 1'b0, 16'h3ca5, 4'h0});
        // Two cycles let the one allowed write finish before counting
        apb(1'b1, 8'h30, 32'h00a5_0011);
        wait_done(c);
        wait_done(c);
        s = snsr.log_q.size();
        wait_done(c);
        wait_done(c);
        cmp(32'(snsr.log_q.size()), 32'(s));
        apb(1'b0, 8'h31, 32'h0);
        cmp(rd_q & 32'h20, 32'h20);
    endtask
    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        #200000;
        bad_count++;
        finish_test();
    end
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_cycle();
        t_rate();
        finish_test();
    end
endmodule
`default_nettype wire
